// *** rtl/status_flag_pkg.sv ***
// Constants for the CPU status-flag unit: register offsets, field positions, resets.
// Assumes a plain register port with one-cycle-late read data.
package status_flag_pkg;

   // ==========================================================================
   // Register offsets
   localparam logic [7:0] SYS_FLAGS_ADDR = 8'h00;
   localparam logic [7:0] ACC_FLAGS_ADDR = 8'h01;
   localparam logic [7:0] COMM_FLAGS_ADDR = 8'h02;
   localparam logic [7:0] CONTROL_ADDR = 8'h03;
   localparam logic [7:0] SYNTAX_CODE_ADDR = 8'h04;
   localparam logic [7:0] SYS_CLEAR_ADDR = 8'h05;

   // ==========================================================================
   // Widths
   localparam int SLOT_COUNT = 8;
   localparam int SYS_WIDTH = 10;
   localparam int ACC_WIDTH = 15;

   // ==========================================================================
   // System flag positions
   localparam int CRIT_BIT = 0;
   localparam int WARN_BIT = 1;
   localparam int BATT_BIT = 2;
   localparam int COMM_BIT = 3;
   localparam int CFG_BIT = 4;
   localparam int FAULT_BIT = 5;
   localparam int WDOG_BIT = 6;
   localparam int SYNTAX_BIT = 7;
   localparam int SOLVE_BIT = 8;
   localparam int SMART_BIT = 9;

   // ==========================================================================
   // Accumulator flag positions
   localparam int LT_BIT = 0;
   localparam int EQ_BIT = 1;
   localparam int GT_BIT = 2;
   localparam int ZERO_BIT = 3;
   localparam int B16_BIT = 4;
   localparam int B32_BIT = 5;
   localparam int C16_BIT = 6;
   localparam int C32_BIT = 7;
   localparam int SIGN_BIT = 8;
   localparam int OCT_BIT = 9;
   localparam int REAL_BIT = 10;
   localparam int OVF_BIT = 11;
   localparam int UNF_BIT = 12;
   localparam int BCD_BIT = 13;
   localparam int LDZ_BIT = 14;

   // ==========================================================================
   // Communication flag positions and control field
   localparam int P2_ACT_BIT = 0;
   localparam int P2_ERR_BIT = 1;
   localparam int SLOT_BASE = 2;
   localparam int CFG_CHECK_EN_BIT = 0;

   // ==========================================================================
   // Reset values
   localparam logic [15:0] SYNTAX_CODE_RESET = 16'h0000;
   localparam logic CFG_CHECK_RESET = 1'b0;

endpackage : status_flag_pkg

// *** rtl/acc_flag_unit.sv ***
// Accumulator-derived status flags, updated when an instruction completes.
// Assumes the instruction executor presents its result with a one-cycle done strobe.
`timescale 1ns/1ps
module acc_flag_unit (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic instr_done,
   input wire logic [31:0] acc_value,
   input wire logic [31:0] operand_value,
   input wire logic is_compare,
   input wire logic is_add16,
   input wire logic is_add32,
   input wire logic is_sub16,
   input wire logic is_sub32,
   input wire logic is_load,
   input wire logic [31:0] arith_a,
   input wire logic [31:0] arith_b,
   input wire logic octal_invalid,
   input wire logic real_invalid,
   input wire logic real_underflow,
   input wire logic bcd_invalid,
   output logic [14:0] flags
);

   // ==========================================================================
   // Arithmetic evaluation
   logic [16:0] sum16;
   logic [32:0] sum32;
   logic [16:0] diff16;
   logic [32:0] diff32;
   logic ovf_add;
   logic ovf_sub;
   logic [14:0] next_flags;

   assign sum16 = {1'b0, arith_a[15:0]} + {1'b0, arith_b[15:0]};
   assign sum32 = {1'b0, arith_a} + {1'b0, arith_b};
   assign diff16 = {1'b0, arith_a[15:0]} - {1'b0, arith_b[15:0]};
   assign diff32 = {1'b0, arith_a} - {1'b0, arith_b};
   assign ovf_add = (arith_a[31] == arith_b[31]) && (sum32[31] != arith_a[31]);
   assign ovf_sub = (arith_a[31] != arith_b[31]) && (diff32[31] != arith_a[31]);

   // Next flag set for the completing instruction
   always_comb begin
      next_flags = flags;
      next_flags[status_flag_pkg::LT_BIT] = 1'b0;
      next_flags[status_flag_pkg::EQ_BIT] = 1'b0;
      next_flags[status_flag_pkg::GT_BIT] = 1'b0;
      if (is_compare) begin
         if (acc_value < operand_value) begin
            next_flags[status_flag_pkg::LT_BIT] = 1'b1;
         end else if (acc_value == operand_value) begin
            next_flags[status_flag_pkg::EQ_BIT] = 1'b1;
         end else begin
            next_flags[status_flag_pkg::GT_BIT] = 1'b1;
         end
      end else begin
         next_flags[2:0] = flags[2:0];
      end
      next_flags[status_flag_pkg::ZERO_BIT] = (acc_value == 32'h0000_0000);
      next_flags[status_flag_pkg::B16_BIT] = is_sub16 & diff16[16];
      next_flags[status_flag_pkg::B32_BIT] = is_sub32 & diff32[32];
      next_flags[status_flag_pkg::C16_BIT] = is_add16 & sum16[16];
      next_flags[status_flag_pkg::C32_BIT] = is_add32 & sum32[32];
      next_flags[status_flag_pkg::SIGN_BIT] = acc_value[31];
      next_flags[status_flag_pkg::OCT_BIT] = octal_invalid;
      next_flags[status_flag_pkg::REAL_BIT] = real_invalid;
      next_flags[status_flag_pkg::UNF_BIT] = real_underflow;
      next_flags[status_flag_pkg::OVF_BIT] = (is_add32 & ovf_add) | (is_sub32 & ovf_sub);
      next_flags[status_flag_pkg::BCD_BIT] = bcd_invalid;
      next_flags[status_flag_pkg::LDZ_BIT] = is_load & (acc_value == 32'h0000_0000);
   end

   // Flags latch on completion and hold between instructions
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         flags <= 15'h0000;
      end else if (instr_done) begin
         flags <= next_flags;
      end
   end

   a_flags_hold: assert property (@(posedge sys_clk) disable iff (rst)
      !instr_done |=> $stable(flags)) else $error("Flags changed without instruction");
   a_cmp_onehot: assert property (@(posedge sys_clk) disable iff (rst)
      instr_done && is_compare |=> $onehot(flags[2:0])) else $error("Compare not one-hot");
   a_zero_flag: assert property (@(posedge sys_clk) disable iff (rst)
      instr_done |=> flags[status_flag_pkg::ZERO_BIT] == ($past(acc_value) == 32'h0000_0000))
      else $error("Zero flag wrong");
   a_sign_flag: assert property (@(posedge sys_clk) disable iff (rst)
      instr_done |=> flags[status_flag_pkg::SIGN_BIT] == $past(acc_value[31]))
      else $error("Sign flag wrong");
   a_carry_16: assert property (@(posedge sys_clk) disable iff (rst)
      instr_done && !is_add16 |=> !flags[status_flag_pkg::C16_BIT])
      else $error("Carry16 without add");
   c_compare_lt: cover property (@(posedge sys_clk) instr_done && is_compare
      ##1 flags[status_flag_pkg::LT_BIT]);
   c_carry32: cover property (@(posedge sys_clk) flags[status_flag_pkg::C32_BIT]);

endmodule : acc_flag_unit

// *** rtl/cpu_status_flag_unit.sv ***
// Top of the CPU status-flag unit: system error flags, port and slot flags, registers.
// Assumes all event inputs are synchronous to sys_clk; events are single-cycle or level.
`timescale 1ns/1ps
module cpu_status_flag_unit (
   input wire logic sys_clk,
   input wire logic rst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   // System fault events
   input wire logic critical_fault,
   input wire logic noncritical_fault,
   input wire logic battery_low_detect,
   input wire logic config_mismatch,
   input wire logic fault_instr_exec,
   input wire logic watchdog_expired,
   input wire logic syntax_error_event,
   input wire logic [15:0] syntax_error_code,
   input wire logic logic_solve_fail,
   input wire logic smart_module_fault,
   // Accumulator side of the instruction executor
   input wire logic instr_done,
   input wire logic [31:0] acc_value,
   input wire logic [31:0] operand_value,
   input wire logic is_compare,
   input wire logic is_add16,
   input wire logic is_add32,
   input wire logic is_sub16,
   input wire logic is_sub32,
   input wire logic is_load,
   input wire logic [31:0] arith_a,
   input wire logic [31:0] arith_b,
   input wire logic octal_invalid,
   input wire logic real_invalid,
   input wire logic real_underflow,
   input wire logic bcd_invalid,
   // Ports and slots
   input wire logic port_two_busy,
   input wire logic port_two_comm_error,
   input wire logic other_port_comm_error,
   input wire logic [7:0] slot_busy,
   input wire logic [7:0] slot_comm_error,
   input wire logic network_write_instr,
   input wire logic network_read_instr,
   input wire logic [2:0] network_slot,
   // Flag outputs
   output logic [9:0] sys_flags,
   output logic [14:0] acc_flags,
   output logic port_two_active_flag,
   output logic port_two_error_flag,
   output logic [7:0] slot_busy_flag,
   output logic [7:0] slot_error_flag,
   output logic [15:0] syntax_code
);

   // ==========================================================================
   // Assertion clock and reset
   default clocking main_cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   // ==========================================================================
   // Control register
   logic cfg_check_en;
   logic sys_clear_hit;
   logic [9:0] sys_clear_mask;

   assign sys_clear_hit = reg_write && (reg_addr == status_flag_pkg::SYS_CLEAR_ADDR);
   assign sys_clear_mask = sys_clear_hit ? reg_wdata[9:0] : 10'h000;

   // Software enables the power-up configuration check
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cfg_check_en <= status_flag_pkg::CFG_CHECK_RESET;
      end else if (reg_write && reg_addr == status_flag_pkg::CONTROL_ADDR) begin
         cfg_check_en <= reg_wdata[status_flag_pkg::CFG_CHECK_EN_BIT];
      end
   end

   // ==========================================================================
   // System error flags: events set, software write-one clears, set wins; the battery bit only follows battery_low_detect
   logic [9:0] sys_events;
   logic any_port_err;

   assign any_port_err = port_two_comm_error | other_port_comm_error;

   always_comb begin
      sys_events = 10'h000;
      sys_events[status_flag_pkg::CRIT_BIT] = critical_fault;
      sys_events[status_flag_pkg::WARN_BIT] = noncritical_fault | battery_low_detect;
      sys_events[status_flag_pkg::BATT_BIT] = 1'b0;
      sys_events[status_flag_pkg::COMM_BIT] = any_port_err;
      sys_events[status_flag_pkg::CFG_BIT] = config_mismatch & cfg_check_en;
      sys_events[status_flag_pkg::FAULT_BIT] = fault_instr_exec;
      sys_events[status_flag_pkg::WDOG_BIT] = watchdog_expired;
      sys_events[status_flag_pkg::SYNTAX_BIT] = syntax_error_event;
      sys_events[status_flag_pkg::SOLVE_BIT] = logic_solve_fail;
      sys_events[status_flag_pkg::SMART_BIT] = smart_module_fault;
   end

   // Sticky bits, battery bit follows its input directly
   genvar gi;
   generate
      for (gi = 0; gi < status_flag_pkg::SYS_WIDTH; gi++) begin : g_sys
         if (gi == status_flag_pkg::BATT_BIT) begin : g_level
            always_ff @(posedge sys_clk or posedge rst) begin
               if (rst) begin
                  sys_flags[gi] <= 1'b0;
               end else begin
                  sys_flags[gi] <= battery_low_detect;
               end
            end
         end else if (gi == status_flag_pkg::CFG_BIT) begin : g_cfg
            always_ff @(posedge sys_clk or posedge rst) begin
               if (rst) begin
                  sys_flags[gi] <= 1'b0;
               end else if (!cfg_check_en) begin
                  sys_flags[gi] <= 1'b0;
               end else if (sys_events[gi]) begin
                  sys_flags[gi] <= 1'b1;
               end else if (sys_clear_mask[gi]) begin
                  sys_flags[gi] <= 1'b0;
               end
            end
         end else begin : g_sticky
            always_ff @(posedge sys_clk or posedge rst) begin
               if (rst) begin
                  sys_flags[gi] <= 1'b0;
               end else if (sys_events[gi]) begin
                  sys_flags[gi] <= 1'b1;
               end else if (sys_clear_mask[gi]) begin
                  sys_flags[gi] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // Syntax error code word captured with the event
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         syntax_code <= status_flag_pkg::SYNTAX_CODE_RESET;
      end else if (syntax_error_event) begin
         syntax_code <= syntax_error_code;
      end
   end

   // ==========================================================================
   // Accumulator flags
   acc_flag_unit i_acc_flag_unit (
      .sys_clk(sys_clk),
      .rst(rst),
      .instr_done(instr_done),
      .acc_value(acc_value),
      .operand_value(operand_value),
      .is_compare(is_compare),
      .is_add16(is_add16),
      .is_add32(is_add32),
      .is_sub16(is_sub16),
      .is_sub32(is_sub32),
      .is_load(is_load),
      .arith_a(arith_a),
      .arith_b(arith_b),
      .octal_invalid(octal_invalid),
      .real_invalid(real_invalid),
      .real_underflow(real_underflow),
      .bcd_invalid(bcd_invalid),
      .flags(acc_flags)
   );

   // ==========================================================================
   // Port two and slot flags
   // Port two activity follows the port; error is sticky until cleared
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         port_two_active_flag <= 1'b0;
         port_two_error_flag <= 1'b0;
      end else begin
         port_two_active_flag <= port_two_busy;
         if (port_two_comm_error) begin
            port_two_error_flag <= 1'b1;
         end else if (reg_write && reg_addr == status_flag_pkg::COMM_FLAGS_ADDR &&
                      reg_wdata[status_flag_pkg::P2_ERR_BIT]) begin
            port_two_error_flag <= 1'b0;
         end
      end
   end

   // Per-slot busy level and sticky error
   generate
      for (gi = 0; gi < status_flag_pkg::SLOT_COUNT; gi++) begin : g_slot
         always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
               slot_busy_flag[gi] <= 1'b0;
               slot_error_flag[gi] <= 1'b0;
            end else begin
               slot_busy_flag[gi] <= slot_busy[gi];
               if (slot_comm_error[gi]) begin
                  slot_error_flag[gi] <= 1'b1;
               end else if (reg_write && reg_addr == status_flag_pkg::COMM_FLAGS_ADDR &&
                            reg_wdata[status_flag_pkg::SLOT_BASE + 2 * gi + 1]) begin
                  slot_error_flag[gi] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // ==========================================================================
   // Register read port
   logic [31:0] comm_word;

   always_comb begin
      comm_word = 32'h0000_0000;
      comm_word[status_flag_pkg::P2_ACT_BIT] = port_two_active_flag;
      comm_word[status_flag_pkg::P2_ERR_BIT] = port_two_error_flag;
      for (int i = 0; i < status_flag_pkg::SLOT_COUNT; i++) begin
         comm_word[status_flag_pkg::SLOT_BASE + 2 * i] = slot_busy_flag[i];
         comm_word[status_flag_pkg::SLOT_BASE + 2 * i + 1] = slot_error_flag[i];
      end
   end

   // Read data stand in the cycle after the strobe only
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_read) begin
         case (reg_addr)
            status_flag_pkg::SYS_FLAGS_ADDR: reg_rdata <= {22'h00_0000, sys_flags};
            status_flag_pkg::ACC_FLAGS_ADDR: reg_rdata <= {17'h0_0000, acc_flags};
            status_flag_pkg::COMM_FLAGS_ADDR: reg_rdata <= comm_word;
            status_flag_pkg::CONTROL_ADDR: reg_rdata <= {31'h0000_0000, cfg_check_en};
            status_flag_pkg::SYNTAX_CODE_ADDR: reg_rdata <= {16'h0000, syntax_code};
            default: reg_rdata <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

   // ==========================================================================
   // Checks
   a_crit_sets: assert property (@(posedge sys_clk) disable iff (rst)
      critical_fault |=> sys_flags[status_flag_pkg::CRIT_BIT]) else $error("Critical not set");
   a_warn_sets: assert property (@(posedge sys_clk) disable iff (rst)
      noncritical_fault |=> sys_flags[status_flag_pkg::WARN_BIT]) else $error("Warning not set");
   a_batt_follow: assert property (@(posedge sys_clk) disable iff (rst)
      ##1 sys_flags[status_flag_pkg::BATT_BIT] == $past(battery_low_detect))
      else $error("Battery flag mismatch");
   a_comm_any: assert property (@(posedge sys_clk) disable iff (rst)
      other_port_comm_error |=> sys_flags[status_flag_pkg::COMM_BIT]) else $error("Comm not set");
   a_cfg_gated: assert property (@(posedge sys_clk) disable iff (rst)
      !cfg_check_en |=> !sys_flags[status_flag_pkg::CFG_BIT]) else $error("Config flag ungated");
   a_wdog_sets: assert property (@(posedge sys_clk) disable iff (rst)
      watchdog_expired |=> sys_flags[status_flag_pkg::WDOG_BIT]) else $error("Watchdog not set");
   a_syntax_code: assert property (@(posedge sys_clk) disable iff (rst)
      syntax_error_event |=> sys_flags[status_flag_pkg::SYNTAX_BIT] &&
      syntax_code == $past(syntax_error_code)) else $error("Syntax code lost");
   a_solve_sets: assert property (@(posedge sys_clk) disable iff (rst)
      logic_solve_fail |=> sys_flags[status_flag_pkg::SOLVE_BIT]) else $error("Solve not set");
   a_port_two: assert property (@(posedge sys_clk) disable iff (rst)
      port_two_comm_error |=> port_two_error_flag && sys_flags[status_flag_pkg::COMM_BIT])
      else $error("Port two error lost");
   a_slot_busy: assert property (@(posedge sys_clk) disable iff (rst)
      ##1 slot_busy_flag == $past(slot_busy)) else $error("Slot busy mismatch");
   a_read_late: assert property (@(posedge sys_clk) disable iff (rst)
      !reg_read |=> reg_rdata == 32'h0000_0000) else $error("Read data outside slot");
   c_cfg_err: cover property (@(posedge sys_clk) cfg_check_en && config_mismatch
      ##1 sys_flags[status_flag_pkg::CFG_BIT]);
   c_clear_flag: cover property (@(posedge sys_clk) sys_flags[status_flag_pkg::CRIT_BIT]
      && sys_clear_hit ##1 !sys_flags[status_flag_pkg::CRIT_BIT]);
   c_net_idle_slot: cover property (@(posedge sys_clk) network_write_instr &&
      !slot_busy_flag[network_slot]);

   // ==========================================================================
   // Sticky behaviour, clears and read mapping, on the default clock
   a_fault_sets: assert property (fault_instr_exec |=>
      sys_flags[status_flag_pkg::FAULT_BIT]) else $error("Fault flag not set");

   a_smart_sets: assert property (smart_module_fault |=>
      sys_flags[status_flag_pkg::SMART_BIT]) else $error("Smart module flag not set");

   a_cfg_sets: assert property (cfg_check_en && config_mismatch |=>
      sys_flags[status_flag_pkg::CFG_BIT]) else $error("Config flag not set");

   a_warn_battery: assert property (battery_low_detect |=>
      sys_flags[status_flag_pkg::WARN_BIT]) else $error("Warning not set by battery");

   a_crit_sticky: assert property (sys_flags[status_flag_pkg::CRIT_BIT] &&
      !sys_clear_mask[status_flag_pkg::CRIT_BIT] |=> sys_flags[status_flag_pkg::CRIT_BIT])
      else $error("Critical flag dropped");

   a_crit_clears: assert property (sys_clear_mask[status_flag_pkg::CRIT_BIT] &&
      !critical_fault |=> !sys_flags[status_flag_pkg::CRIT_BIT]) else $error("Clear ignored");

   a_port_active: assert property (##1 port_two_active_flag == $past(port_two_busy))
      else $error("Port two activity mismatch");

   a_port_sticky: assert property (port_two_error_flag && !reg_write |=>
      port_two_error_flag) else $error("Port two error dropped");

   a_slot_err_sets: assert property (slot_comm_error != 8'h00 |=>
      (slot_error_flag & $past(slot_comm_error)) == $past(slot_comm_error))
      else $error("Slot error not set");

   a_slot_sticky: assert property (!reg_write |=>
      (slot_error_flag & $past(slot_error_flag)) == $past(slot_error_flag))
      else $error("Slot error dropped");

   a_syntax_hold: assert property (!syntax_error_event |=> $stable(syntax_code))
      else $error("Syntax code changed");

   a_read_sys: assert property (reg_read && reg_addr == status_flag_pkg::SYS_FLAGS_ADDR |=>
      reg_rdata == {22'h00_0000, $past(sys_flags)}) else $error("System read wrong");

   a_read_ctrl: assert property (reg_read && reg_addr == status_flag_pkg::CONTROL_ADDR |=>
      reg_rdata[0] == $past(cfg_check_en)) else $error("Control read wrong");

   a_read_comm: assert property (reg_read &&
      reg_addr == status_flag_pkg::COMM_FLAGS_ADDR |=>
      reg_rdata[status_flag_pkg::P2_ERR_BIT] == $past(port_two_error_flag))
      else $error("Comm read wrong");

endmodule : cpu_status_flag_unit

// *** verification/cpu_status_flag_unit_bench.sv ***
// Self-checking bench for the status-flag unit: system, accumulator and comm flags.
// Assumes the package is compiled first; the bench drives every port itself.
`timescale 1ns/1ps
module cpu_status_flag_unit_bench;
   // ==========================================================================
   // Signals and model state
   logic sys_clk = 0, rst = 1, reg_write = 0, reg_read = 0, instr_done = 0, is_compare = 0;
   logic is_add16 = 0, is_add32 = 0, is_sub16 = 0, is_sub32 = 0, is_load = 0, octal_invalid = 0;
   logic real_invalid = 0, real_underflow = 0, bcd_invalid = 0, port_two_busy = 0;
   logic port_two_comm_error = 0, network_write_instr = 0, network_read_instr = 0, pa, pe;
   logic port_two_active_flag, port_two_error_flag;
   logic [2:0] network_slot = 0, op, cmp;
   logic [7:0] reg_addr = 0, slot_busy = 0, slot_comm_error = 0, slot_busy_flag, sb, se;
   logic [7:0] slot_error_flag;
   logic [9:0] ev = 0, sys_flags;
   logic [14:0] acc_flags;
   logic [15:0] syntax_error_code = 0, syntax_code;
   logic [31:0] reg_wdata = 0, reg_rdata, acc_value = 0, operand_value = 0, arith_a = 0;
   logic [31:0] arith_b = 0, a, b, v, o, q, w, expv, seed = 32'h0000_002b;
   logic [32:0] s;
   int errors = 0, checks_done = 0, cycles = 0;

   cpu_status_flag_unit i_cpu_status_flag_unit (.sys_clk, .rst, .reg_addr, .reg_wdata,
      .reg_write, .reg_read, .reg_rdata, .critical_fault(ev[0]), .noncritical_fault(ev[1]),
      .battery_low_detect(ev[2]), .config_mismatch(ev[4]), .fault_instr_exec(ev[5]),
      .watchdog_expired(ev[6]), .syntax_error_event(ev[7]), .syntax_error_code,
      .logic_solve_fail(ev[8]), .smart_module_fault(ev[9]), .instr_done, .acc_value,
      .operand_value, .is_compare, .is_add16, .is_add32, .is_sub16, .is_sub32, .is_load,
      .arith_a, .arith_b, .octal_invalid, .real_invalid, .real_underflow, .bcd_invalid,
      .port_two_busy, .port_two_comm_error, .other_port_comm_error(ev[3]), .slot_busy,
      .slot_comm_error, .network_write_instr, .network_read_instr, .network_slot,
      .sys_flags, .acc_flags, .port_two_active_flag, .port_two_error_flag, .slot_busy_flag,
      .slot_error_flag, .syntax_code);

   // Clock and hang guard
   always #2.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         errors = errors + 1;
         complete_run();
      end
   end

   // ==========================================================================
   // Helpers
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   task automatic check(input logic [63:0] seen, input logic [63:0] want);
      checks_done++;
      if (seen !== want) begin
         errors++;
         $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask : check
   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      @(posedge sys_clk);
      reg_write <= 1'b1;
      reg_addr <= ad;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_write <= 1'b0;
   endtask : wr
   task automatic rdc(input logic [7:0] ad, input logic [31:0] want);
      @(posedge sys_clk);
      reg_read <= 1'b1;
      reg_addr <= ad;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      #1 check(reg_rdata, want);
   endtask : rdc
   task automatic pulse(input int i);
      @(posedge sys_clk);
      ev[i] <= 1'b1;
      @(posedge sys_clk);
      ev[i] <= 1'b0;
      #1;
   endtask : pulse
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : complete_run

   // ==========================================================================
   // Main sequence
   initial begin
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      #1 check({sys_flags, acc_flags, slot_busy_flag, slot_error_flag, syntax_code}, 0);
      // System events one by one, config check still disabled
      syntax_error_code <= 16'(rnd());
      for (int i = 0; i < 10; i++) begin
         expv = (i == 4) ? 0 : (1 << i) | ((i == 2) ? 2 : 0);
         pulse(i);
         check(sys_flags, expv);
         rdc(status_flag_pkg::SYS_FLAGS_ADDR, expv & 32'h0000_03fb);
         wr(status_flag_pkg::SYS_CLEAR_ADDR, 32'h0000_03ff);
      end
      rdc(status_flag_pkg::SYNTAX_CODE_ADDR, syntax_error_code);
      wr(status_flag_pkg::CONTROL_ADDR, 32'h0000_0001);
      rdc(status_flag_pkg::CONTROL_ADDR, 32'h0000_0001);
      pulse(4);
      wr(status_flag_pkg::SYS_FLAGS_ADDR, 32'h0000_0000);
      rdc(status_flag_pkg::SYS_FLAGS_ADDR, 32'h0000_0010);
      wr(status_flag_pkg::CONTROL_ADDR, 32'h0000_0000);
      rdc(status_flag_pkg::SYS_FLAGS_ADDR, 32'h0000_0000);
      wr(status_flag_pkg::SYS_CLEAR_ADDR, 32'h0000_03ff);
      rdc(status_flag_pkg::SYS_FLAGS_ADDR, 32'h0000_0000);
      rdc(8'h07, 32'h0000_0000);
      $display("system flag test done");
      // Random instructions; cycles without done must leave the flags alone
      expv = 0;
      cmp = 0;
      for (int k = 0; k < 300; k++) begin
         op = 3'(rnd() % 7);
         a = rnd();
         b = rnd();
         v = (rnd() % 3 != 0) ? rnd() : 0;
         o = rnd() % 2 ? v : rnd();
         q = rnd();
         if (op == 1 || op == 3) a = a & 32'h0000_ffff;
         if (op == 1 || op == 3) b = b & 32'h0000_ffff;
         @(posedge sys_clk);
         instr_done <= q[0];
         is_compare <= op == 0;
         is_add16 <= op == 1;
         is_add32 <= op == 2;
         is_sub16 <= op == 3;
         is_sub32 <= op == 4;
         is_load <= op == 5;
         acc_value <= v;
         operand_value <= o;
         arith_a <= a;
         arith_b <= b;
         {octal_invalid, real_invalid, real_underflow, bcd_invalid} <= q[4:1];
         #1 check(acc_flags, expv);
         s = {1'b0, a} + b;
         w = a - b;
         if (q[0] && op == 0) cmp = (v < o) ? 3'h1 : (v == o) ? 3'h2 : 3'h4;
         if (q[0]) expv = {op == 5 && v == 0, q[1], q[2],
            (op == 2 && a[31] == b[31] && s[31] != a[31]) ||
            (op == 4 && a[31] != b[31] && a[31] != w[31]), q[3], q[4], v[31],
            op == 2 && s[32], op == 1 && s[16], op == 4 && a < b, op == 3 && a < b, v == 0, cmp};
      end
      $display("accumulator flag test done");
      // Port and slot flags: busy follows one cycle late, errors stick
      pe = 0;
      se = 0;
      for (int k = 0; k < 40; k++) begin
         q = rnd();
         @(posedge sys_clk);
         port_two_busy <= q[0];
         slot_busy <= q[15:8];
         port_two_comm_error <= q[3:1] == 0;
         slot_comm_error <= q[23:16] & q[31:24];
         #1 if (k > 0) check({port_two_error_flag, port_two_active_flag, slot_error_flag,
            slot_busy_flag}, {pe, pa, se, sb});
         pa = q[0];
         sb = q[15:8];
         pe = pe | (q[3:1] == 0);
         se = se | (q[23:16] & q[31:24]);
      end
      @(posedge sys_clk);
      {port_two_busy, slot_busy, port_two_comm_error, slot_comm_error} <= 0;
      w = pe << 1;
      for (int k = 0; k < 8; k++) w = w | (se[k] << (3 + 2 * k));
      rdc(status_flag_pkg::COMM_FLAGS_ADDR, w);
      wr(status_flag_pkg::COMM_FLAGS_ADDR, 32'hffff_ffff);
      rdc(status_flag_pkg::COMM_FLAGS_ADDR, 32'h0000_0000);
      // Network access only to an idle slot
      @(posedge sys_clk);
      network_slot <= 3'h3;
      network_write_instr <= 1'b1;
      @(posedge sys_clk);
      network_write_instr <= 1'b0;
      network_read_instr <= 1'b1;
      @(posedge sys_clk);
      network_read_instr <= 1'b0;
      $display("comm flag test done");
      complete_run();
   end
endmodule : cpu_status_flag_unit_bench
